// file: inc/adc_seq_pkg.sv
// constants, field layout and types of the conversion sequencer
package adc_seq_pkg;
  localparam int CLK_PS   = 25000;
  localparam int TCL_PS   = 12500;
  localparam int TCC24_CYC = (24 * TCL_PS + CLK_PS - 1) / CLK_PS;
  localparam int TCC48_CYC = (48 * TCL_PS + CLK_PS - 1) / CLK_PS;
  localparam int TCC96_CYC = (96 * TCL_PS + CLK_PS - 1) / CLK_PS;

  localparam logic [2:0] A_CTRL   = 3'h0;
  localparam logic [2:0] A_RESULT = 3'h1;
  localparam logic [2:0] A_INJRES = 3'h2;
  localparam logic [2:0] A_INJCTL = 3'h3;
  localparam logic [2:0] A_STAT   = 3'h4;
  localparam logic [2:0] A_MASK   = 3'h5;
  localparam logic [2:0] A_PINS   = 3'h6;

  localparam int CH_LSB    = 0;
  localparam int MODE_LSB  = 4;
  localparam int START_BIT = 6;
  localparam int OVRH_BIT  = 7;
  localparam int INJ_BIT   = 8;
  localparam int WFR_BIT   = 9;
  localparam int STC_LSB   = 12;
  localparam int CTC_LSB   = 14;
  localparam int RCH_LSB   = 12;

  localparam int ST_DONE = 0;
  localparam int ST_OVR  = 1;
  localparam int ST_INJ  = 2;

  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] ZERO16   = 16'h0000;

  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_SAMPLE = 2'b01,
    S_CONV   = 2'b10,
    S_HOLD   = 2'b11
  } state_e;

  typedef enum logic [1:0] {
    M_SINGLE = 2'b00,
    M_CONT   = 2'b01,
    M_SCAN   = 2'b10,
    M_SCANC  = 2'b11
  } mode_e;
endpackage

// file: rtl/adc_conversion_sequencer.sv
// conversion sequencer for the 10-bit multiplexed converter core
// Operation
// RULE_01 - results are 10 bits, one of 16 channels is muxed in and held during sampling.
// RULE_02 - with error policy, a result finishing while the last is unread flags an overrun.
// RULE_03 - with hold policy, the next conversion waits until the last result is read.
// RULE_04 - the analog pins stay readable as plain digital inputs.
// RULE_05 - single channel single mode converts the channel once, stores it, and stops.
// RULE_06 - single channel continuous mode converts the same channel again and again.
// RULE_07 - scan single mode converts each channel once in turn, storing each result.
// RULE_08 - scan continuous mode cycles through the channels without end.
// RULE_09 - wait-for-read in a continuous mode parks a new result and pauses until a read.
// RULE_10 - an injection request in a continuous mode converts one channel into its own register.
// RULE_11 - after an injected conversion the running continuous mode resumes by itself.
// RULE_12 - the conversion clock field picks 24, 96 or 48 base clock phases per period.
// RULE_13 - the sample clock field picks one, two, four or eight conversion periods.
// RULE_14 - software never writes the reserved conversion clock code.
// RULE_15 - the channel field picks the single channel or the scan start; scans count down.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int CONV_TCC = 10
) (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic [2:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic [15:0] DIGITAL_PINS,
  input  wire logic [9:0]  CONV_DATA,
  output logic      [3:0]  MUX_SEL,
  output logic             SAMPLE_EN,
  output logic             CONVERT_EN,
  output logic             IRQ
);

  typedef struct packed {
    state_e      st;
    logic [15:0] cnt;
    logic [3:0]  ch;
    logic [3:0]  start_ch;
    logic [3:0]  inj_ch;
    logic        inj_act;
    logic        inj_pend;
    logic        unread;
    logic [15:0] ctrl;
    logic [9:0]  res;
    logic [3:0]  res_ch;
    logic [9:0]  tmp;
    logic [3:0]  tmp_ch;
    logic [9:0]  ires;
    logic [3:0]  ires_ch;
    logic [2:0]  stat;
    logic [2:0]  mask;
    logic [15:0] p1;
    logic [15:0] p2;
    logic [9:0]  d1;
    logic [9:0]  d2;
    logic [15:0] rdata;
    logic [3:0]  mux;
    logic        samp;
    logic        conv;
    logic        irq;
  } state_s;

  state_s q_r;
  state_s q_nxt;

  function automatic logic [15:0] tcc_cyc(input logic [15:0] c);
    case (c[CTC_LSB +: 2])
      2'b10:   tcc_cyc = 16'(TCC96_CYC); // RULE_12
      2'b11:   tcc_cyc = 16'(TCC48_CYC); // RULE_12
      default: tcc_cyc = 16'(TCC24_CYC); // RULE_12 RULE_14
    endcase
  endfunction

  function automatic logic [15:0] samp_load(input logic [15:0] c);
    samp_load = (tcc_cyc(c) << c[STC_LSB +: 2]) - 16'h0001; // RULE_13
  endfunction

  function automatic logic [15:0] conv_load(input logic [15:0] c);
    conv_load = 16'(tcc_cyc(c) * CONV_TCC) - 16'h0001; // RULE_12
  endfunction

  mode_e       mode;
  logic        ctrl_wr;
  logic        rd_res;
  logic        park;
  logic        fin;
  logic        more;
  logic [3:0]  next_ch;

  always_comb begin
    mode    = mode_e'(q_r.ctrl[MODE_LSB +: 2]);
    ctrl_wr = WR && (ADDR == A_CTRL);
    rd_res  = RD && (ADDR == A_RESULT);
    fin     = (q_r.st == S_CONV) && (q_r.cnt == ZERO16);
    park    = q_r.ctrl[OVRH_BIT] || (q_r.ctrl[WFR_BIT] && q_r.ctrl[MODE_LSB]); // RULE_03 RULE_09
    case (mode)
      M_SINGLE: begin
        more    = 1'b0;
        next_ch = q_r.ch;
      end
      M_CONT: begin
        more    = 1'b1; // RULE_06
        next_ch = q_r.ch;
      end
      M_SCAN: begin
        more    = (q_r.ch != 4'h0); // RULE_07
        next_ch = q_r.ch - 4'h1;
      end
      default: begin
        more    = 1'b1; // RULE_08
        next_ch = (q_r.ch == 4'h0) ? q_r.start_ch : q_r.ch - 4'h1; // RULE_15
      end
    endcase
  end

  logic        adv;
  logic [2:0]  ev;
  logic [2:0]  w1c;

  always_comb begin
    q_nxt    = q_r;
    adv      = 1'b0;
    ev       = 3'b000;
    w1c      = 3'b000;
    q_nxt.p1 = DIGITAL_PINS;
    q_nxt.p2 = q_r.p1;
    q_nxt.d1 = CONV_DATA;
    q_nxt.d2 = q_r.d1;
    q_nxt.rdata = ZERO16;
    if (RD) begin
      case (ADDR)
        A_CTRL:   q_nxt.rdata = {q_r.ctrl[15:7], q_r.st != S_IDLE, q_r.ctrl[5:0]};
        A_RESULT: q_nxt.rdata = {q_r.res_ch, 2'b00, q_r.res};
        A_INJRES: q_nxt.rdata = {q_r.ires_ch, 2'b00, q_r.ires};
        A_INJCTL: q_nxt.rdata = {7'h00, q_r.inj_pend, 4'h0, q_r.inj_ch};
        A_STAT:   q_nxt.rdata = {13'h0000, q_r.stat};
        A_MASK:   q_nxt.rdata = {13'h0000, q_r.mask};
        A_PINS:   q_nxt.rdata = q_r.p2; // RULE_04
        default:  q_nxt.rdata = ZERO16;
      endcase
    end
    if (WR) begin
      case (ADDR)
        A_CTRL:   q_nxt.ctrl = WDATA & ~(16'h0001 << START_BIT);
        A_INJCTL: begin
          if (!q_r.inj_act) begin
            q_nxt.inj_ch = WDATA[CH_LSB +: 4]; // RULE_01
          end
          if (WDATA[INJ_BIT]) begin
            q_nxt.inj_pend = 1'b1; // RULE_10
          end
        end
        A_STAT:   w1c = WDATA[2:0];
        A_MASK:   q_nxt.mask = WDATA[2:0];
        default:  ;
      endcase
    end
    if (rd_res) begin
      q_nxt.unread = 1'b0;
    end
    case (q_r.st)
      S_IDLE: begin
        if (ctrl_wr && WDATA[START_BIT]) begin
          q_nxt.ch       = WDATA[CH_LSB +: 4]; // RULE_15
          q_nxt.start_ch = WDATA[CH_LSB +: 4]; // RULE_15
          q_nxt.st       = S_SAMPLE;
          q_nxt.cnt      = samp_load(q_nxt.ctrl); // RULE_13
        end
      end
      S_SAMPLE: begin
        if (q_r.cnt == ZERO16) begin
          q_nxt.st  = S_CONV;
          q_nxt.cnt = conv_load(q_nxt.ctrl); // RULE_12
        end else begin
          q_nxt.cnt = q_r.cnt - 16'h0001;
        end
      end
      S_CONV: begin
        if (q_r.cnt != ZERO16) begin
          q_nxt.cnt = q_r.cnt - 16'h0001;
        end else if (q_r.inj_act) begin
          q_nxt.ires    = q_r.d2; // RULE_10
          q_nxt.ires_ch = q_r.inj_ch;
          q_nxt.inj_act = 1'b0; // RULE_11
          ev[ST_INJ]    = 1'b1;
          q_nxt.st      = S_SAMPLE; // RULE_11
          q_nxt.cnt     = samp_load(q_nxt.ctrl);
        end else if (q_r.unread && !rd_res && park) begin
          q_nxt.tmp    = q_r.d2; // RULE_09
          q_nxt.tmp_ch = q_r.ch;
          q_nxt.st     = S_HOLD; // RULE_03
        end else begin
          if (q_r.unread && !rd_res) begin
            ev[ST_OVR] = 1'b1; // RULE_02
          end
          q_nxt.res    = q_r.d2; // RULE_05 RULE_06 RULE_07 RULE_08
          q_nxt.res_ch = q_r.ch;
          q_nxt.unread = 1'b1;
          ev[ST_DONE]  = 1'b1;
          adv          = 1'b1;
        end
      end
      S_HOLD: begin
        if (rd_res) begin
          q_nxt.res    = q_r.tmp; // RULE_09
          q_nxt.res_ch = q_r.tmp_ch;
          q_nxt.unread = 1'b1;
          ev[ST_DONE]  = 1'b1;
          adv          = 1'b1;
        end
      end
      default: q_nxt.st = S_IDLE;
    endcase
    if (adv) begin
      if (more) begin
        q_nxt.ch  = next_ch;
        q_nxt.st  = S_SAMPLE;
        q_nxt.cnt = samp_load(q_nxt.ctrl);
        if (q_nxt.inj_pend && q_r.ctrl[MODE_LSB]) begin
          q_nxt.inj_act  = 1'b1; // RULE_10
          q_nxt.inj_pend = 1'b0;
        end
      end else begin
        q_nxt.st = S_IDLE; // RULE_05 RULE_07
      end
    end
    if (ctrl_wr && !WDATA[START_BIT]) begin
      q_nxt.st      = S_IDLE;
      q_nxt.inj_act = 1'b0;
    end
    q_nxt.stat = (q_r.stat & ~w1c) | ev;
    q_nxt.irq  = |(q_nxt.stat & q_nxt.mask);
    q_nxt.samp = (q_nxt.st == S_SAMPLE);
    q_nxt.conv = (q_nxt.st == S_CONV);
    q_nxt.mux  = q_nxt.inj_act ? q_nxt.inj_ch : q_nxt.ch; // RULE_01
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      q_r      <= '0;
      q_r.st   <= S_IDLE;
      q_r.ctrl <= CTRL_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign RDATA      = q_r.rdata;
  assign MUX_SEL    = q_r.mux;
  assign SAMPLE_EN  = q_r.samp;
  assign CONVERT_EN = q_r.conv;
  assign IRQ        = q_r.irq;

  logic reg_done;
  assign reg_done = fin && !q_r.inj_act && !(q_r.unread && !rd_res && park) && !ctrl_wr;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_mux_stable: assert property (q_r.samp && $past(q_r.samp) |-> $stable(MUX_SEL)) // RULE_01
    else $error("channel select moved during sampling");
  a_overrun_flag: assert property (reg_done && q_r.unread && !rd_res |=> q_r.stat[ST_OVR]) // RULE_02
    else $error("overrun not flagged");
  a_hold_off: assert property (q_r.st == S_HOLD && !rd_res && !ctrl_wr |=> !SAMPLE_EN) // RULE_03
    else $error("conversion resumed before read");
  a_pin_read: assert property (RD && ADDR == A_PINS |=> RDATA == $past(q_r.p2)) // RULE_04
    else $error("pin readback wrong");
  a_single_stop: assert property (reg_done && mode == M_SINGLE |=> q_r.st == S_IDLE) // RULE_05
    else $error("single conversion did not stop");
  a_cont_repeat: assert property (reg_done && mode == M_CONT |=> SAMPLE_EN && q_r.ch == $past(q_r.ch)) // RULE_06
    else $error("continuous mode changed channel");
  a_scan_step: assert property (reg_done && mode == M_SCAN && q_r.ch != 4'h0
    |=> q_r.ch == $past(q_r.ch) - 4'h1) // RULE_07
    else $error("scan did not step down");
  a_scan_wrap: assert property (reg_done && mode == M_SCANC && q_r.ch == 4'h0
    |=> SAMPLE_EN && q_r.ch == q_r.start_ch) // RULE_08
    else $error("scan did not wrap");
  a_wait_park: assert property (fin && !q_r.inj_act && q_r.unread && !rd_res && park && !ctrl_wr
    |=> q_r.st == S_HOLD ##1 (q_r.st == S_HOLD || $past(rd_res) || $past(ctrl_wr))) // RULE_09
    else $error("result not parked");
  a_inj_result: assert property (fin && q_r.inj_act |=> q_r.ires == $past(q_r.d2) && q_r.stat[ST_INJ]) // RULE_10
    else $error("injected result lost");
  a_inj_resume: assert property (fin && q_r.inj_act && !ctrl_wr
    |=> SAMPLE_EN && !q_r.inj_act && MUX_SEL == q_r.ch) // RULE_11
    else $error("mode not resumed after injection");
  a_inj_chan_hold: assert property (q_r.inj_act && $past(q_r.inj_act) // RULE_10
    |-> $stable(q_r.inj_ch))
    else $error("injection channel moved");
  a_conv_time: assert property ($rose(CONVERT_EN) |-> q_r.cnt == conv_load(q_r.ctrl)) // RULE_12
    else $error("conversion time wrong");
  a_samp_time: assert property ($rose(SAMPLE_EN) |-> q_r.cnt == samp_load(q_r.ctrl)) // RULE_13
    else $error("sample time wrong");
  a_start_chan: assert property (q_r.st == S_IDLE && ctrl_wr && WDATA[START_BIT]
    |=> q_r.ch == $past(WDATA[3:0])) // RULE_15
    else $error("start channel wrong");

endmodule

// file: dv/conv_core_model.sv
// behavioural converter core: channel-coded value while converting
`timescale 1ns/1ps
module conv_core_model (
  input  wire logic       CLOCK,
  input  wire logic [3:0] MUX_SEL,
  input  wire logic       CONVERT_EN,
  output logic      [9:0] CONV_DATA
);
  initial CONV_DATA = 10'h155;
  // idle output toggles so a late capture shows
  always @(posedge CLOCK) begin
    CONV_DATA <= CONVERT_EN ? {6'h2D, MUX_SEL} : ~CONV_DATA;
  end
endmodule

// file: dv/adc_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_tb
  import adc_seq_pkg::*;
;
  logic        CLOCK = 0, RESET = 1, WR = 0, RD = 0;
  logic [2:0]  ADDR = 3'h0;
  logic [15:0] WDATA = 16'h0000, DIGITAL_PINS = 16'h0000, RDATA;
  logic [9:0]  CONV_DATA;
  logic [3:0]  MUX_SEL;
  logic        SAMPLE_EN, CONVERT_EN, IRQ;
  int          n_errors = 0, compares = 0;
  always #12.5 CLOCK = ~CLOCK;
  adc_conversion_sequencer #(.CONV_TCC(1)) uut (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DIGITAL_PINS(DIGITAL_PINS),
    .CONV_DATA(CONV_DATA), .MUX_SEL(MUX_SEL), .SAMPLE_EN(SAMPLE_EN),
    .CONVERT_EN(CONVERT_EN), .IRQ(IRQ));
  conv_core_model core (.CLOCK(CLOCK), .MUX_SEL(MUX_SEL), .CONVERT_EN(CONVERT_EN),
    .CONV_DATA(CONV_DATA));
  task automatic wr(logic [2:0] a, logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, output logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge CLOCK);
    #1;
  endtask
  // waits for a high run of sample or convert, returns its length
  task automatic meas(bit conv, output int n);
    n = 0;
    #1;
    for (int i = 0; i < 3000 && (conv ? CONVERT_EN : SAMPLE_EN) !== 1'b1; i++) begin
      @(posedge CLOCK);
      #1;
    end
    while ((conv ? CONVERT_EN : SAMPLE_EN) === 1'b1 && n < 3000) begin
      n++;
      @(posedge CLOCK);
      #1;
    end
  endtask
  function automatic logic [15:0] res(logic [3:0] c);
    return {c, 2'b00, 6'h2D, c};
  endfunction
  task automatic quiet();
    logic [15:0] d;
    wr(A_CTRL, ZERO16);
    rd(A_RESULT, d);
    rd(A_RESULT, d);
    wr(A_STAT, 16'h0007);
    wr(A_MASK, ZERO16);
  endtask
  task automatic endt(string s);
    $display("test %s finished, errors %0d", s, n_errors);
  endtask
  task automatic t_single();
    logic [15:0] d;
    int n;
    quiet();
    wr(A_MASK, 16'h0001);
    wr(A_CTRL, 16'h0045);
    meas(1, n);
    chk(16'(n), 16'h000C);
    settle();
    chk(16'(IRQ), 16'h0001);
    rd(A_RESULT, d);
    chk(d, res(4'h5));
    rd(A_CTRL, d);
    chk(16'(d[START_BIT]), 16'h0000);
    wr(A_MASK, ZERO16);
    settle();
    chk(16'(IRQ), 16'h0000);
    wr(A_MASK, 16'h0001);
    wr(A_STAT, 16'h0001);
    settle();
    chk(16'(IRQ), 16'h0000);
  endtask
  task automatic t_clk();
    logic [1:0] cc [3] = '{2'b00, 2'b10, 2'b11};
    int ph [3] = '{24, 96, 48};
    int n;
    quiet();
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 4; s++) begin
        wr(A_CTRL, {cc[k], 2'(s), 12'h040});
        meas(0, n);
        chk(16'(n), 16'((ph[k] / 2) << s));
        meas(1, n);
        chk(16'(n), 16'(ph[k] / 2));
      end
    end
  endtask
  task automatic t_scan();
    logic [15:0] d;
    int n;
    quiet();
    wr(A_CTRL, 16'h0062);
    for (int c = 2; c >= 0; c--) begin
      meas(1, n);
      rd(A_RESULT, d);
      chk(d, res(4'(c)));
    end
    settle();
    chk(16'(SAMPLE_EN), 16'h0000);
  endtask
  task automatic t_ovr(logic [15:0] pol);
    logic [15:0] d;
    logic hi;
    int n;
    quiet();
    wr(A_MASK, 16'h0002);
    wr(A_CTRL, 16'h0054 | pol);
    meas(1, n);
    meas(1, n);
    hi = 1'b0;
    repeat (60) @(posedge CLOCK) #1 hi |= SAMPLE_EN;
    chk(16'(hi), 16'(pol == ZERO16));
    rd(A_STAT, d);
    chk(16'(d[ST_OVR]), 16'(pol == ZERO16));
    chk(16'(IRQ), 16'(pol == ZERO16));
    rd(A_RESULT, d);
    chk(d, res(4'h4));
    rd(A_RESULT, d);
    chk(d, res(4'h4));
    meas(1, n);
    meas(0, n);
    chk(16'(n), 16'h000C);
  endtask
  task automatic t_inj();
    logic [15:0] d;
    int n;
    quiet();
    wr(A_CTRL, 16'h0071);
    wr(A_INJCTL, 16'h0109);
    d = ZERO16;
    for (int i = 0; i < 100 && d[ST_INJ] !== 1'b1; i++) rd(A_STAT, d);
    rd(A_INJRES, d);
    chk(d, res(4'h9));
    rd(A_CTRL, d);
    chk(16'(d[START_BIT]), 16'h0001);
    meas(1, n);
    meas(0, n);
    chk(16'(n), 16'h000C);
    chk(16'(MUX_SEL), 16'h0001);
    meas(1, n);
    rd(A_RESULT, d);
    chk(d, res(4'h1));
  endtask
  task automatic t_pins();
    logic [15:0] d;
    @(posedge CLOCK);
    DIGITAL_PINS <= 16'hA5C3;
    settle();
    rd(A_PINS, d);
    chk(d, 16'hA5C3);
    rd(3'h7, d);
    chk(d, ZERO16);
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge CLOCK);
    RESET <= 1'b0;
    t_single();
    endt("single");
    t_clk();
    endt("clocks");
    t_scan();
    endt("scan");
    t_ovr(ZERO16);
    endt("overrun");
    t_ovr(16'h0080);
    endt("hold");
    t_ovr(16'h0200);
    endt("wait_for_read");
    t_inj();
    endt("injection");
    t_pins();
    endt("pins");
    final_report();
  end
  initial begin
    repeat (40000) @(posedge CLOCK);
    n_errors++;
    final_report();
  end
endmodule
